//--- verilog/pot_device.sv
// Potentiometer end: two-wire slave, wiper and preset registers
`timescale 1ns/10ps
`default_nettype none
`include "pot_defines.svh"
module pot_device
    import pot_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Two-wire link
    pot_bus_if.dev bus,
    // Address straps and write protect
    input wire logic addr_pin_bit0,
    input wire logic addr_pin_bit2,
    input wire logic addr_pin_bit3,
    input wire logic wp_b,
    // Wiper state and nonvolatile write busy
    output logic [63:0] wiper_sel,
    output wiper_t wiper_position_reg_r,
    output logic nv_busy
);

    localparam int BW = $clog2(NV_WRITE_CYCLES + 1);

    if (NV_WRITE_CYCLES < 1) begin : g_bad_nv
        $error("NV_WRITE_CYCLES must be at least one");
    end

    // Synchronisers
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [2:0] pin_m;
    logic [2:0] pin_q;
    logic wp_m;
    logic wp_q;
    logic scl_d;
    logic sda_d;

    // Protocol state
    dev_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] instr_r;
    logic sda_low_r;

    // Storage
    wiper_t preset_r [4];
    logic nv_pend_r;
    logic [BW-1:0] busy_cnt_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], bus.scl};
            sda_s <= {sda_s[0], bus.sda};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_m <= 3'h0;
            pin_q <= 3'h0;
            wp_m <= 1'b0;
            wp_q <= 1'b0;
        end else begin
            pin_m <= {addr_pin_bit3, addr_pin_bit2, addr_pin_bit0};
            pin_q <= pin_m;
            wp_m <= wp_b;
            wp_q <= wp_m;
        end
    end

    // Line events; data moving while the clock is high marks a frame edge
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_s[1] & !scl_d;
    assign scl_fall = !scl_s[1] & scl_d;
    assign start_det = scl_s[1] & scl_d & sda_d & !sda_s[1];
    assign stop_det = scl_s[1] & scl_d & !sda_d & sda_s[1];

    // Decode of the byte just received
    logic [3:0] op_now;
    logic [1:0] sel_now;
    logic addr_match;
    logic cmd_ok;
    logic byte_ack;
    logic slot_end;
    logic cmd_evt;
    logic data_evt;
    logic [7:0] rd_byte;
    logic nv_wr_evt;

    assign op_now = shift_r[7:4];
    assign sel_now = shift_r[3:2];
    assign addr_match = (shift_r[7:4] == `DEV_TYPE_ID)
        && (shift_r[2:0] == pin_q)
        && !nv_busy;
    assign cmd_ok = (shift_r[1:0] == 2'h0)
        && ((op_now == `OP_RD_WIPER) || (op_now == `OP_WR_WIPER)
        || (op_now == `OP_RD_DR) || (op_now == `OP_WR_DR)
        || (op_now == `OP_XFR_DR_WIPER) || (op_now == `OP_XFR_WIPER_DR)
        || (op_now == `OP_INCDEC));

    always_comb begin
        case (state_r)
            D_ADDR: byte_ack = addr_match;
            D_CMD: byte_ack = cmd_ok;
            D_WDATA: byte_ack = 1'b1;
            default: byte_ack = 1'b0;
        endcase
    end

    assign slot_end = scl_fall && (cnt_r == 4'h8);
    assign cmd_evt = slot_end && (state_r == D_CMD) && cmd_ok;
    assign data_evt = slot_end && (state_r == D_WDATA);
    assign rd_byte = {2'h0, (op_now == `OP_RD_WIPER) ? wiper_position_reg_r : preset_r[sel_now]};
    assign nv_wr_evt = wp_q && ((data_evt && (instr_r[7:4] == `OP_WR_DR))
        || (cmd_evt && (op_now == `OP_XFR_WIPER_DR)));

    // Bit and byte sequencing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= D_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            instr_r <= 8'h00;
            sda_low_r <= 1'b0;
        end else if (start_det) begin
            state_r <= D_ADDR;
            cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= D_IDLE;
            sda_low_r <= 1'b0;
        end else if ((state_r != D_IDLE) && (state_r != D_INCDEC)) begin
            if (scl_rise) begin
                if (cnt_r < 4'h8) begin
                    shift_r <= {shift_r[6:0], sda_s[1]};
                end
                cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
                if (cnt_r == 4'h8) begin
                    if (state_r == D_RDATA) begin
                        sda_low_r <= 1'b0;
                    end else begin
                        sda_low_r <= byte_ack;
                        if (!byte_ack) begin
                            state_r <= D_IDLE;
                        end
                    end
                    if (state_r == D_CMD) begin
                        instr_r <= shift_r;
                    end
                end else if (cnt_r == 4'h9) begin
                    cnt_r <= 4'h0;
                    sda_low_r <= 1'b0;
                    case (state_r)
                        D_ADDR: state_r <= D_CMD;
                        D_CMD: begin
                            if ((op_now == `OP_WR_WIPER) || (op_now == `OP_WR_DR)) begin
                                state_r <= D_WDATA;
                            end else if ((op_now == `OP_RD_WIPER) || (op_now == `OP_RD_DR)) begin
                                state_r <= D_RDATA;
                                shift_r <= rd_byte;
                                sda_low_r <= !rd_byte[7];
                            end else if (op_now == `OP_INCDEC) begin
                                state_r <= D_INCDEC;
                            end else begin
                                state_r <= D_IDLE;
                            end
                        end
                        default: state_r <= D_IDLE;
                    endcase
                end else if (state_r == D_RDATA) begin
                    // Own bit was shifted in at the rise, so the next sits on top
                    sda_low_r <= !shift_r[7];
                end
            end
        end
    end

    // Pull-down only, never a driven high
    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe = sda_low_r;

    // Wiper position register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wiper_position_reg_r <= `WIPER_RESET;
        end else if (data_evt && (instr_r[7:4] == `OP_WR_WIPER)) begin
            wiper_position_reg_r <= shift_r[5:0];
        end else if (cmd_evt && (op_now == `OP_XFR_DR_WIPER)) begin
            wiper_position_reg_r <= preset_r[sel_now];
        end else if ((state_r == D_INCDEC) && scl_rise) begin
            if (sda_s[1] && (wiper_position_reg_r != 6'h3F)) begin
                wiper_position_reg_r <= wiper_position_reg_r + 6'h01;
            end else if (!sda_s[1] && (wiper_position_reg_r != 6'h00)) begin
                wiper_position_reg_r <= wiper_position_reg_r - 6'h01;
            end
        end
    end

    // One switch closed at a time
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wiper_sel <= 64'h1 << `WIPER_RESET;
        end else begin
            wiper_sel <= 64'h1 << wiper_position_reg_r;
        end
    end

    // Preset registers; reset stands for the stored contents
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                preset_r[i] <= `WIPER_RESET;
            end
        end else if (nv_wr_evt) begin
            if (data_evt) begin
                preset_r[instr_r[3:2]] <= shift_r[5:0];
            end else begin
                preset_r[sel_now] <= wiper_position_reg_r;
            end
        end
    end

    // Nonvolatile write interval starts at the closing stop
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nv_pend_r <= 1'b0;
            busy_cnt_r <= '0;
            nv_busy <= 1'b0;
        end else begin
            if (nv_wr_evt) begin
                nv_pend_r <= 1'b1;
            end else if (stop_det && nv_pend_r) begin
                nv_pend_r <= 1'b0;
                busy_cnt_r <= BW'(NV_WRITE_CYCLES);
                nv_busy <= 1'b1;
            end else if (busy_cnt_r != '0) begin
                busy_cnt_r <= busy_cnt_r - BW'(1);
                nv_busy <= (busy_cnt_r != BW'(1));
            end
        end
    end

endmodule : pot_device
`default_nettype wire

//--- verilog/pot_defines.svh
// Constants of the digital potentiometer slave and its two-wire host
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

// Device-type nibble of the slave address; value is arbitrary
`define DEV_TYPE_ID 4'hA

// Opcodes in the upper nibble of the command byte
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'hA
`define OP_RD_DR 4'hB
`define OP_WR_DR 4'hC
`define OP_XFR_DR_WIPER 4'hD
`define OP_XFR_WIPER_DR 4'hE
`define OP_INCDEC 4'h2

// Preset contents at power-up, and so the first wiper value
`define WIPER_RESET 6'h20

// Timing
`define MCLK_MHZ 200
`define NV_WRITE_MS 5
`define NV_WRITE_CYCLES (`NV_WRITE_MS * 1000 * `MCLK_MHZ)
`define SCL_QTR_CYCLES 125

// Host registers, byte addresses
`define REG_CMD 4'h0
`define REG_ADDR 4'h4
`define REG_STAT 4'h8

// Host register fields
`define CMD_DATA_LSB 8
`define CMD_UP_BIT 16
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_RDATA_LSB 8

`endif

//--- verilog/pot_pkg.sv
// Types shared by the potentiometer slave and its host
package pot_pkg;
    typedef logic [5:0] wiper_t;
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_CMD, D_WDATA, D_RDATA, D_INCDEC} dev_state_t;
    typedef enum logic [2:0] {M_IDLE, M_START, M_BYTE, M_PULSE, M_STOP} mst_state_t;
endpackage : pot_pkg

//--- verilog/pot_bus_if.sv
// Two-wire link between the potentiometer slave and its host
`timescale 1ns/10ps
`default_nettype none
interface pot_bus_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;

    // Wired level of the data line with its pull-up
    assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
    modport mst (output scl, output m_sda_o, output m_sda_oe, input sda);
endinterface : pot_bus_if
`default_nettype wire

//--- verilog/pot_master.sv
// Host end: Avalon-MM command registers driving the two-wire link
`timescale 1ns/10ps
`default_nettype none
`include "pot_defines.svh"
module pot_master
    import pot_pkg::*;
#(
    parameter int QTR_CYCLES = `SCL_QTR_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Two-wire link
    pot_bus_if.mst bus
);

    localparam int QW = $clog2(QTR_CYCLES);

    if (QTR_CYCLES < 8) begin : g_bad_qtr
        $error("QTR_CYCLES must be at least 8");
    end

    logic [16:0] cmd_r;
    logic [3:0] addr_r;
    logic busy_r;
    logic nack_r;
    logic [7:0] rdata_r;
    logic [1:0] sda_s;
    logic [QW-1:0] qdiv_r;
    logic [1:0] qp_r;
    mst_state_t state_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic [7:0] pcnt_r;
    logic fail_r;
    logic scl_r;
    logic sda_low_r;
    logic sda_o_r;

    logic acc;
    logic go;
    logic tick;
    logic [3:0] op;
    logic rx;
    logic [7:0] txb;
    assign acc = (avs_read || avs_write) && !avs_waitrequest;
    assign go = acc && avs_write && (avs_address == `REG_CMD) && !busy_r;
    assign tick = (qdiv_r == QW'(QTR_CYCLES - 1));
    assign op = cmd_r[7:4];
    assign rx = (byte_r == 2'h2) && ((op == `OP_RD_WIPER) || (op == `OP_RD_DR));
    assign txb = (byte_r == 2'h0) ? {`DEV_TYPE_ID, addr_r}
        : (byte_r == 2'h1) ? cmd_r[7:0] : cmd_r[15:8];

    // One wait cycle, then the access is taken
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                if (avs_address == `REG_CMD) begin
                    avs_readdata <= {15'h0, cmd_r};
                end else if (avs_address == `REG_ADDR) begin
                    avs_readdata <= {28'h0, addr_r};
                end else if (avs_address == `REG_STAT) begin
                    avs_readdata <= {16'h0, rdata_r, 6'h0, nack_r, busy_r};
                end else begin
                    avs_readdata <= 32'h0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_r <= 17'h0;
            addr_r <= 4'h0;
        end else if (go) begin
            cmd_r <= avs_writedata[16:0];
        end else if (acc && avs_write && (avs_address == `REG_ADDR)) begin
            addr_r <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sda_s <= 2'h3;
            sda_o_r <= 1'b0;
        end else begin
            sda_s <= {sda_s[0], bus.sda};
        end
    end

    // Quarter-bit divider; the host alone makes the clock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            qdiv_r <= '0;
        end else if ((state_r == M_IDLE) || tick) begin
            qdiv_r <= '0;
        end else begin
            qdiv_r <= qdiv_r + QW'(1);
        end
    end

    // Frame sequencer; bit data moves only in quarter 0, clock low; start and stop move it with clock high
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= M_IDLE;
            qp_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            pcnt_r <= 8'h0;
            fail_r <= 1'b0;
            busy_r <= 1'b0;
            nack_r <= 1'b0;
            rdata_r <= 8'h0;
            scl_r <= 1'b1;
            sda_low_r <= 1'b0;
        end else if (go) begin
            state_r <= M_START;
            qp_r <= 2'h0;
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            fail_r <= 1'b0;
            byte_r <= 2'h0;
            pcnt_r <= avs_writedata[15:8];
        end else if (tick) begin
            qp_r <= qp_r + 2'h1;
            case (state_r)
                M_START: begin
                    if (qp_r == 2'h1) begin
                        sda_low_r <= 1'b1;
                    end else if (qp_r == 2'h3) begin
                        scl_r <= 1'b0;
                        state_r <= M_BYTE;
                        bit_r <= 4'h0;
                    end
                end
                M_BYTE: begin
                    if (qp_r == 2'h0) begin
                        sda_low_r <= (bit_r < 4'h8) && !rx && !txb[3'h7 - bit_r[2:0]];
                    end else if (qp_r == 2'h1) begin
                        scl_r <= 1'b1;
                    end else if (qp_r == 2'h2) begin
                        if ((bit_r < 4'h8) && rx) begin
                            rdata_r <= {rdata_r[6:0], sda_s[1]};
                        end
                        fail_r <= (bit_r == 4'h8) && !rx && sda_s[1];
                    end else begin
                        scl_r <= 1'b0;
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h8) begin
                            bit_r <= 4'h0;
                            byte_r <= byte_r + 2'h1;
                            if (fail_r) begin
                                nack_r <= 1'b1;
                                state_r <= M_STOP;
                            end else if (byte_r == 2'h0) begin
                                state_r <= M_BYTE;
                            end else if ((byte_r == 2'h1) && (op == `OP_INCDEC)) begin
                                state_r <= (pcnt_r != 8'h0) ? M_PULSE : M_STOP;
                            end else if ((byte_r == 2'h1) && (op != `OP_XFR_DR_WIPER)
                                && (op != `OP_XFR_WIPER_DR)) begin
                                state_r <= M_BYTE;
                            end else begin
                                state_r <= M_STOP;
                            end
                        end
                    end
                end
                M_PULSE: begin
                    if (qp_r == 2'h0) begin
                        sda_low_r <= !cmd_r[`CMD_UP_BIT];
                    end else if (qp_r == 2'h1) begin
                        scl_r <= 1'b1;
                    end else if (qp_r == 2'h3) begin
                        scl_r <= 1'b0;
                        pcnt_r <= pcnt_r - 8'h1;
                        if (pcnt_r == 8'h1) begin
                            state_r <= M_STOP;
                        end
                    end
                end
                M_STOP: begin
                    if (qp_r == 2'h0) begin
                        sda_low_r <= 1'b1;
                    end else if (qp_r == 2'h1) begin
                        scl_r <= 1'b1;
                    end else if (qp_r == 2'h2) begin
                        sda_low_r <= 1'b0;
                    end else begin
                        state_r <= M_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                default: qp_r <= 2'h0;
            endcase
        end
    end

    assign bus.scl = scl_r;
    assign bus.m_sda_o = sda_o_r;
    assign bus.m_sda_oe = sda_low_r;

endmodule : pot_master
`default_nettype wire

//--- verification/pot_link_asserts.sv
// Link checker watching the wire between the potentiometer slave and its host
`timescale 1ns/10ps
`default_nettype none
module pot_link_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Link signals
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic sda
);
    logic sda_q_r;
    logic seen_start_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Remembers whether any start condition has crossed the wire
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sda_q_r <= 1'b1;
            seen_start_r <= 1'b0;
        end else begin
            sda_q_r <= sda;
            if (scl && sda_q_r && !sda) begin
                seen_start_r <= 1'b1;
            end
        end
    end

    AST_DEV_OPEN_DRAIN: assert property (d_sda_oe |-> d_sda_o == 1'b0)
        else $error("device drives data line high");
    AST_MST_OPEN_DRAIN: assert property (m_sda_oe |-> m_sda_o == 1'b0)
        else $error("host drives data line high");
    AST_DEV_STILL_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
        else $error("device moved data while clock high");
    AST_DEV_PULL_EARLY: assert property ($rose(d_sda_oe) |-> !scl [*8])
        else $error("device pull not early in clock low phase");
    AST_DEV_RELEASE_EARLY: assert property ($fell(d_sda_oe) |-> !scl [*8])
        else $error("device release not early in clock low phase");
    AST_DEV_RELEASE_BOUND: assert property ($rose(d_sda_oe) |-> ##[1:600] !d_sda_oe)
        else $error("device held data line too long");
    AST_QUIET_BEFORE_START: assert property (!seen_start_r |-> !d_sda_oe)
        else $error("device answered before any start");
    AST_START_CLOCKS: assert property ($rose(m_sda_oe) && scl |-> ##[1:40] !scl)
        else $error("no clock low after start");
    AST_STOP_IDLE: assert property ($fell(m_sda_oe) && scl |-> scl [*8])
        else $error("clock pulsed right after stop");
endmodule : pot_link_asserts
`default_nettype wire

//--- verification/tb_top.sv
// Testbench joining the potentiometer slave and its host over the two-wire link
`timescale 1ns/10ps
`default_nettype none
`include "pot_defines.svh"
module tb_top;
    typedef struct {logic [31:0] m; logic [31:0] e;} note_t;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] pins = 3'h0;
    logic wp_b = 1'b1;
    logic [63:0] wiper_sel;
    logic [5:0] wiper_position_reg_r;
    logic nv_busy;
    int fail_count = 0;
    int checks = 0;
    int seed;
    note_t notes[$];
    logic [5:0] v;
    logic [5:0] d[4];
    logic [31:0] r;

    always #2.5 mclk = ~mclk;

    pot_bus_if bus_i ();
    pot_device #(.NV_WRITE_CYCLES(1000)) i_pot_device (.mclk(mclk), .rst_b(rst_b), .bus(bus_i),
        .addr_pin_bit0(pins[0]), .addr_pin_bit2(pins[1]), .addr_pin_bit3(pins[2]), .wp_b(wp_b),
        .wiper_sel(wiper_sel), .wiper_position_reg_r(wiper_position_reg_r), .nv_busy(nv_busy));
    pot_master #(.QTR_CYCLES(8)) i_pot_master (.mclk(mclk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus(bus_i));
    pot_link_asserts i_pot_link_asserts (.mclk(mclk), .rst_b(rst_b), .scl(bus_i.scl),
        .m_sda_o(bus_i.m_sda_o), .m_sda_oe(bus_i.m_sda_oe), .d_sda_o(bus_i.d_sda_o),
        .d_sda_oe(bus_i.d_sda_oe), .sda(bus_i.sda));

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // One Avalon access; an idle edge follows so requests never merge
    task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : av

    // Issues a command, polls until the frame ends, then notes the expected status
    task automatic run(input logic [31:0] c, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        av(`REG_CMD, 1'b1, c, q);
        do begin
            notes.push_back('{32'h0, 32'h0});
            av(`REG_STAT, 1'b0, 32'h0, q);
        end while (q[`STAT_BUSY_BIT] !== 1'b0);
        notes.push_back('{m, e});
        av(`REG_STAT, 1'b0, 32'h0, q);
    endtask : run

    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            note_t n;
            n = notes.pop_front();
            if (n.m != 32'h0) chk("stat", 64'(n.e & n.m), 64'(avs_readdata & n.m));
        end
    end

    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        seed = 32'h9914;
        pins <= 3'($random(seed));
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        chk("wiper", 64'h20, 64'(wiper_position_reg_r));
        chk("sel", 64'h1 << 32, wiper_sel);
        repeat (3) @(posedge mclk);
        av(`REG_ADDR, 1'b1, {29'h0, pins}, r);
        v = 6'($random(seed));
        run({18'h0, v, 8'hA0}, 32'h3, 32'h0);
        chk("wiper", 64'(v), 64'(wiper_position_reg_r));
        chk("sel", 64'h1 << v, wiper_sel);
        run(32'h90, 32'hFF01, {18'h0, v, 8'h0});
        for (int k = 0; k < 4; k++) begin
            d[k] = 6'($random(seed));
            run({18'h0, d[k], 8'hC0 | 8'(k << 2)}, 32'h3, 32'h0);
            chk("nv_busy", 64'h1, 64'(nv_busy));
            run(32'h90, 32'h3, 32'h2);
            while (nv_busy !== 1'b0) @(posedge mclk);
            run(32'hB0 | 32'(k << 2), 32'hFF03, {18'h0, d[k], 8'h0});
        end
        run(32'hD8, 32'h3, 32'h0);
        chk("wiper", 64'(d[2]), 64'(wiper_position_reg_r));
        run(32'hEC, 32'h3, 32'h0);
        while (nv_busy !== 1'b0) @(posedge mclk);
        run(32'hBC, 32'hFF03, {18'h0, d[2], 8'h0});
        wp_b <= 1'b0;
        run({18'h0, ~d[1], 8'hC4}, 32'h3, 32'h0);
        chk("nv_busy", 64'h0, 64'(nv_busy));
        run(32'hB4, 32'hFF03, {18'h0, d[1], 8'h0});
        wp_b <= 1'b1;
        run(32'hA1, 32'h3, 32'h2);
        av(`REG_ADDR, 1'b1, {29'h0, pins ^ 3'h1}, r);
        run({18'h0, ~d[2], 8'hA0}, 32'h3, 32'h2);
        chk("wiper", 64'(d[2]), 64'(wiper_position_reg_r));
        av(`REG_ADDR, 1'b1, {29'h0, pins}, r);
        // Steps saturate at the ends; the clock rise before stop steps down once
        run({18'h0, 6'd60, 8'hA0}, 32'h3, 32'h0);
        run({15'h0, 1'b1, 8'd10, 8'h20}, 32'h3, 32'h0);
        chk("wiper", 64'd62, 64'(wiper_position_reg_r));
        run({18'h0, 6'd3, 8'hA0}, 32'h3, 32'h0);
        run({15'h0, 1'b0, 8'd5, 8'h20}, 32'h3, 32'h0);
        chk("wiper", 64'd0, 64'(wiper_position_reg_r));
        chk("sel", 64'h1, wiper_sel);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
